// ===== hw/acr_cfg_mem.sv
// Snapshot memory for the stored configuration slots.
`timescale 1ns/100ps
module acr_cfg_mem #(
    parameter int W = 32,
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    input wire logic clk,
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [W-1:0] wrData,
    input wire logic [AW-1:0] rdAddr,
    output logic [W-1:0] rdData_reg
);
    // Storage has no reset; a valid mask outside covers empty slots.
    logic [W-1:0] memArr [DEPTH];

    // ----------------------------------------------------------------
    // Write port and registered read port
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (wrEn) begin
            memArr[wrAddr] <= wrData;
        end
        rdData_reg <= memArr[rdAddr];
    end
endmodule : acr_cfg_mem

// ===== hw/acr_defines.svh
// Constants for the automatic configuration recovery sequencer.
`ifndef ACR_DEFINES_SVH
`define ACR_DEFINES_SVH
// ----------------------------------------------------------------
// Register word addresses
// ----------------------------------------------------------------
`define ACR_ADDR_CTRL 4'h0
`define ACR_ADDR_CMD 4'h1
`define ACR_ADDR_CFG 4'h2
`define ACR_ADDR_STAT 4'h3
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ACR_CTRL_TXEN 0
`define ACR_CTRL_MUTE 1
`define ACR_CMD_STORE 4
`define ACR_CMD_RECALL 5
`define ACR_TIME_SEL 3
// ----------------------------------------------------------------
// Values and timing
// ----------------------------------------------------------------
`define ACR_NUM_SLOTS 8
`define ACR_FACTORY_SLOT 4'h8
`define ACR_TIME_MAX 14400
`define ACR_TIME_W 14
`define ACR_DWELL_W 15
`define ACR_SEC_NS 1000000000
`define ACR_CLK_NS 40
`define ACR_SEC_CYCLES (`ACR_SEC_NS / `ACR_CLK_NS)
`endif

// ===== hw/acr_pkg.sv
// Types shared by the recovery sequencer.
package acr_pkg;
    // Loader states, Gray coded along boot, idle, read, load.
    typedef enum logic [1:0] {
        ST_BOOT = 2'b00,
        ST_IDLE = 2'b01,
        ST_READ = 2'b11,
        ST_LOAD = 2'b10
    } acr_state_t;
    // Slot number: 0..7 user slots, 8 factory set.
    typedef logic [3:0] acr_slot_t;
endpackage : acr_pkg

// ===== hw/acr_sec_tick.sv
// One-second time base derived from the system clock.
`timescale 1ns/100ps
module acr_sec_tick #(
    parameter int CYCLES = 25000000
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic restart,
    output logic tick_reg
);
    // Cycle counter within the current second.
    logic [31:0] cnt_reg;
    // Last cycle of the second.
    wire lastCyc = (cnt_reg == 32'(CYCLES - 1));

    // ----------------------------------------------------------------
    // Counter; restart aligns seconds to the start of a dwell.
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst || restart || lastCyc) begin
            cnt_reg <= 32'h0;
        end else begin
            cnt_reg <= cnt_reg + 32'h1;
        end
    end

    // Tick is a one-cycle pulse at the end of each whole second.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= lastCyc && !restart;
        end
    end
endmodule : acr_sec_tick

// ===== hw/acr_sequencer.sv
// Configuration store, recall and automatic recovery sequencer.
//
// Implementation choices: strobed register access and the register addresses.
`include "acr_defines.svh"
`timescale 1ns/100ps
module acr_sequencer
    import acr_pkg::*;
#(
    parameter int CFG_W = 32,
    parameter logic [CFG_W-1:0] FACTORY_CFG = 32'h0000_0000,
    parameter int SEC_CYCLES = `ACR_SEC_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0] addr,
    input wire logic [31:0] wrData,
    input wire logic wrStb,
    input wire logic rdStb,
    output logic [31:0] rdData_reg,
    input wire logic carrierLock,
    input wire logic redundMode,
    input wire logic [3:0] pwrUpSlot,
    input wire logic [CFG_W-1:0] resumeCfg,
    output logic [CFG_W-1:0] cfg_reg,
    output logic [3:0] activeSlot_reg,
    output logic loadPulse_reg,
    output logic txCarrierOn_reg
);
    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------
    // First armed slot after position from, wrapping past slot 7.
    function automatic logic [2:0] nextArmed(input logic [7:0] mask,
                                             input logic [2:0] from);
        logic [2:0] idx;
        logic [2:0] res;
        logic hit;
        res = 3'h0;
        hit = 1'b0;
        for (int k = 1; k <= 8; k++) begin
            idx = 3'(from + k);
            if (!hit && mask[idx]) begin
                res = idx;
                hit = 1'b1;
            end
        end
        return res;
    endfunction : nextArmed

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    acr_state_t state_reg;        // Loader state.
    acr_state_t state_next;       // Its next value.
    logic [3:0] rdSlot_reg;       // Slot being recalled.
    logic [3:0] rdSlot_next;      // Its next value.
    logic [7:0] slotValid_reg;    // Slots that hold a user snapshot.
    logic [`ACR_TIME_W-1:0] time_reg [`ACR_NUM_SLOTS]; // Dwell times.
    logic [`ACR_DWELL_W-1:0] dwell_reg; // Seconds without carrier.
    logic seqRun_reg;             // A recovery sequence is under way.
    logic [2:0] lastTgt_reg;      // Slot loaded by the last step.
    logic txEn_reg;               // Software transmit enable.
    logic mute_reg;               // Carrier lock alarm action is mute.
    logic [CFG_W-1:0] memRd;      // Snapshot read data.
    logic secTick;                // One-second pulse.

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire isTime = addr[`ACR_TIME_SEL];
    wire wrCtrl = wrStb && !isTime && addr == `ACR_ADDR_CTRL;
    wire wrCmd = wrStb && !isTime && addr == `ACR_ADDR_CMD;
    wire wrCfg = wrStb && !isTime && addr == `ACR_ADDR_CFG;
    wire [3:0] cmdSlot = wrData[3:0];
    wire cmdStore = wrCmd && wrData[`ACR_CMD_STORE] && !cmdSlot[3];
    wire cmdRecall = wrCmd && wrData[`ACR_CMD_RECALL] &&
                     cmdSlot <= `ACR_FACTORY_SLOT;
    // times above the limit are refused
    wire timeOk = wrData <= 32'(`ACR_TIME_MAX);
    wire wrTime = wrStb && isTime && timeOk;

    // Slots with a nonzero dwell time are armed for recovery.
    wire [7:0] armMask;
    genvar gi;
    generate
        for (gi = 0; gi < `ACR_NUM_SLOTS; gi++) begin : g_arm
            assign armMask[gi] = time_reg[gi] != '0;
        end
    endgenerate

    // fresh loss starts at lowest armed slot
    wire [2:0] firstTgt = nextArmed(armMask, 3'h7);
    // later steps take the next armed slot, wrapping
    wire [2:0] stepTgt = nextArmed(armMask, lastTgt_reg);
    wire [2:0] target = seqRun_reg ? stepTgt : firstTgt;
    // the target's time is the dwell here before moving
    wire dwellDone = dwell_reg >= {1'b0, time_reg[target]};
    // carrier absent long enough, not in redundancy
    wire stepDue = state_reg == ST_IDLE && !carrierLock &&
                   !redundMode && armMask != 8'h00 && dwellDone &&
                   !cmdRecall;
    wire bootRecall = pwrUpSlot != 4'h0 && pwrUpSlot <= 4'h8;
    // never-stored slots give the factory set
    wire useFactory = rdSlot_reg[3] || !slotValid_reg[rdSlot_reg[2:0]];
    wire [CFG_W-1:0] loadCfg = useFactory ? FACTORY_CFG : memRd;
    wire loading = state_reg == ST_LOAD;
    wire dwellSat = &dwell_reg;

    // ----------------------------------------------------------------
    // Submodules
    // ----------------------------------------------------------------
    acr_cfg_mem #(
        .W(CFG_W),
        .DEPTH(`ACR_NUM_SLOTS),
        .AW(3)
    ) u_mem (
        .clk(clk),
        .wrEn(cmdStore),
        .wrAddr(cmdSlot[2:0]),
        .wrData(cfg_reg),
        .rdAddr(rdSlot_reg[2:0]),
        .rdData_reg(memRd)
    );

    // Seconds restart whenever the dwell restarts.
    acr_sec_tick #(
        .CYCLES(SEC_CYCLES)
    ) u_tick (
        .clk(clk),
        .sys_rst(sys_rst),
        .restart(carrierLock || loading),
        .tick_reg(secTick)
    );

    // ----------------------------------------------------------------
    // Loader state machine
    // ----------------------------------------------------------------
    // Recall requests are taken only in idle; loads take two cycles, read then load.
    always_comb begin
        state_next = state_reg;
        rdSlot_next = rdSlot_reg;
        case (state_reg)
            ST_BOOT: begin
                if (bootRecall) begin
                    rdSlot_next = pwrUpSlot - 4'h1;
                    state_next = ST_READ;
                end else begin
                    state_next = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (cmdRecall) begin
                    rdSlot_next = cmdSlot;
                    state_next = ST_READ;
                end else if (stepDue) begin
                    rdSlot_next = {1'b0, target};
                    state_next = ST_READ;
                end
            end
            ST_READ: state_next = ST_LOAD;
            ST_LOAD: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    // State registers.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= ST_BOOT;
            rdSlot_reg <= 4'h0;
        end else begin
            state_reg <= state_next;
            rdSlot_reg <= rdSlot_next;
        end
    end

    // ----------------------------------------------------------------
    // Active configuration
    // ----------------------------------------------------------------
    // A load wins over a software write in the same cycle, because a
    // half-applied recall would leave the modem on an unknown setup.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg_reg <= FACTORY_CFG;
            activeSlot_reg <= `ACR_FACTORY_SLOT;
        end else if (state_reg == ST_BOOT && !bootRecall) begin
            cfg_reg <= resumeCfg;
        end else if (loading) begin
            cfg_reg <= loadCfg;
            activeSlot_reg <= rdSlot_reg;
        end else if (wrCfg) begin
            cfg_reg <= wrData[CFG_W-1:0];
        end
    end

    // Load strobe for the configuration storage outside.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            loadPulse_reg <= 1'b0;
        end else begin
            loadPulse_reg <= loading;
        end
    end

    // ----------------------------------------------------------------
    // Slot bookkeeping
    // ----------------------------------------------------------------
    // all slots read as factory after reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            slotValid_reg <= 8'h00;
        end else if (cmdStore) begin
            slotValid_reg[cmdSlot[2:0]] <= 1'b1;
        end
    end

    // per-slot recovery time, zero by default
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < `ACR_NUM_SLOTS; i++) begin
                time_reg[i] <= '0;
            end
        end else if (wrTime) begin
            time_reg[addr[2:0]] <= wrData[`ACR_TIME_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Dwell counter and sequence tracking
    // ----------------------------------------------------------------
    // clear on lock or load, count seconds otherwise
    always_ff @(posedge clk) begin
        if (sys_rst || carrierLock || loading) begin
            dwell_reg <= '0;
        end else if (secTick && !dwellSat) begin
            dwell_reg <= dwell_reg + 1'b1;
        end
    end

    // lock ends the sequence; stepping keeps it running
    always_ff @(posedge clk) begin
        if (sys_rst || carrierLock) begin
            seqRun_reg <= 1'b0;
        end else if (stepDue) begin
            seqRun_reg <= 1'b1;
        end
    end

    // Remember the slot last entered by a step.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lastTgt_reg <= 3'h0;
        end else if (stepDue) begin
            lastTgt_reg <= target;
        end
    end

    // ----------------------------------------------------------------
    // Control register and transmit carrier
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            txEn_reg <= 1'b0;
            mute_reg <= 1'b0;
        end else if (wrCtrl) begin
            txEn_reg <= wrData[`ACR_CTRL_TXEN];
            mute_reg <= wrData[`ACR_CTRL_MUTE];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            txCarrierOn_reg <= 1'b0;
        end else begin
            txCarrierOn_reg <= txEn_reg && !(mute_reg && !carrierLock);
        end
    end

    // ----------------------------------------------------------------
    // Read data, valid only in the cycle after the read strobe
    // ----------------------------------------------------------------
    wire [31:0] statWord = {9'h0, seqRun_reg, txCarrierOn_reg,
                            carrierLock, activeSlot_reg, 1'b0, dwell_reg};
    wire [31:0] rdMux =
        isTime ? 32'(time_reg[addr[2:0]]) :
        addr == `ACR_ADDR_CTRL ? {30'h0, mute_reg, txEn_reg} :
        addr == `ACR_ADDR_CMD ? {24'h0, slotValid_reg} :
        addr == `ACR_ADDR_CFG ? 32'(cfg_reg) :
        addr == `ACR_ADDR_STAT ? statWord : 32'h0;

    // Unmapped addresses read as zero.
    always_ff @(posedge clk) begin
        if (sys_rst || !rdStb) begin
            rdData_reg <= 32'h0;
        end else begin
            rdData_reg <= rdMux;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    AST_STORE_MARKS:
    assert property (@(posedge clk) disable iff (sys_rst)
        cmdStore |=> slotValid_reg[$past(cmdSlot[2:0])])
        else $error("Stored slot not marked valid.");
    AST_FACTORY_LOAD:
    assert property (@(posedge clk) disable iff (sys_rst)
        loading && rdSlot_reg == `ACR_FACTORY_SLOT |=>
        cfg_reg == FACTORY_CFG)
        else $error("Factory recall loaded wrong data.");
    AST_TIME_LIMIT:
    assert property (@(posedge clk) disable iff (sys_rst)
        time_reg[addr[2:0]] <= `ACR_TIME_W'(`ACR_TIME_MAX))
        else $error("Recovery time above limit.");
    AST_STEP_LOADS:
    assert property (@(posedge clk) disable iff (sys_rst)
        stepDue |-> ##1 state_reg == ST_READ ##1 loading
        ##1 activeSlot_reg == {1'b0, $past(target, 3)})
        else $error("Recovery step did not load target.");
    AST_LOCK_STOPS:
    assert property (@(posedge clk) disable iff (sys_rst)
        carrierLock |=> !seqRun_reg && dwell_reg == '0)
        else $error("Sequence continued after lock.");
    AST_RESTART_LOW:
    assert property (@(posedge clk) disable iff (sys_rst)
        stepDue && !seqRun_reg |->
        (armMask & ((8'h01 << target) - 8'h01)) == 8'h00)
        else $error("Restart skipped a lower armed slot.");
    AST_WRAP:
    assert property (@(posedge clk) disable iff (sys_rst)
        stepDue && seqRun_reg && target <= lastTgt_reg |->
        (armMask >> lastTgt_reg) == 8'h01 ||
        (armMask >> lastTgt_reg) == 8'h00)
        else $error("Wrapped while a higher slot was armed.");
    AST_DWELL_GATE:
    assert property (@(posedge clk) disable iff (sys_rst)
        state_reg == ST_IDLE && state_next == ST_READ && !cmdRecall |->
        dwell_reg >= {1'b0, time_reg[rdSlot_next[2:0]]} && !carrierLock)
        else $error("Step taken before the dwell time ran out.");
    AST_REDUND:
    assert property (@(posedge clk) disable iff (sys_rst)
        redundMode |=> !$rose(seqRun_reg))
        else $error("Stepping while in redundancy mode.");
    AST_BOOT_LAST:
    assert property (@(posedge clk) disable iff (sys_rst)
        state_reg == ST_BOOT && pwrUpSlot == 4'h0 |=>
        cfg_reg == $past(resumeCfg))
        else $error("Power-up did not resume last settings.");
    AST_MUTE:
    assert property (@(posedge clk) disable iff (sys_rst)
        mute_reg && !carrierLock |=> !txCarrierOn_reg)
        else $error("Transmit on without receive carrier.");
    AST_DWELL_TICK:
    assert property (@(posedge clk) disable iff (sys_rst)
        secTick && !carrierLock && !loading && !dwellSat |=>
        dwell_reg == $past(dwell_reg) + 1'b1)
        else $error("Dwell did not count a second.");
endmodule : acr_sequencer

// ===== testbench/acr_demod_model.sv
// Behavioural receive demodulator that locks only on one chosen setup.
`timescale 1ns/100ps
module acr_demod_model #(
    parameter int CFG_W = 32,
    parameter int LOCK_DELAY = 3
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [CFG_W-1:0] cfg,
    input wire logic [CFG_W-1:0] goodCfg,
    output logic carrierLock
);
    // Cycles for which the tuned setup has matched the live carrier.
    int matchCnt;

    // Start unlocked so the sequencer never sees an unknown level.
    initial begin
        carrierLock = 1'b0;
        matchCnt = 0;
    end

    // ----------------------------------------------------------------
    // Lock detector
    // ----------------------------------------------------------------
    // Lock needs a few cycles of a matching setup; any mismatch drops it
    // at once, which is harsher than a real loop but exposes late stops.
    always @(posedge clk) begin
        if (sys_rst || cfg !== goodCfg) begin
            matchCnt <= 0;
            carrierLock <= 1'b0;
        end else if (matchCnt < LOCK_DELAY) begin
            matchCnt <= matchCnt + 1;
        end else begin
            carrierLock <= 1'b1;
        end
    end
endmodule : acr_demod_model

// ===== testbench/tb.sv
// Self-checking bench for the configuration recovery sequencer.
`timescale 1ns/100ps
module tb
    import acr_pkg::*;
;
    // ----------------------------------------------------------------
    // Settings and signals
    // ----------------------------------------------------------------
    localparam int SEC = 20; // Short second keeps the run brief.
    localparam logic [31:0] FACT = 32'hFAC7_0001; // Arbitrary factory set.
    localparam logic [31:0] NONE = 32'hDEAD_0000; // Setup that never locks.
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [31:0] wrData = 32'h0000_0000;
    logic wrStb = 1'b0;
    logic rdStb = 1'b0;
    logic [31:0] rdData_reg;
    logic carrierLock;
    logic redundMode = 1'b0;
    logic [3:0] pwrUpSlot = 4'h0;
    logic [31:0] resumeCfg = 32'h1234_5678;
    logic [31:0] cfg_reg;
    logic [3:0] activeSlot_reg;
    logic loadPulse_reg;
    logic txCarrierOn_reg;
    logic [31:0] goodCfg = NONE; // Setup on which the far carrier locks.
    logic [31:0] rd;
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int cyc;

    always #20 clk = ~clk;

    acr_sequencer #(.FACTORY_CFG(FACT), .SEC_CYCLES(SEC)) u_dut (
        .clk(clk), .sys_rst(sys_rst), .addr(addr), .wrData(wrData),
        .wrStb(wrStb), .rdStb(rdStb), .rdData_reg(rdData_reg),
        .carrierLock(carrierLock), .redundMode(redundMode),
        .pwrUpSlot(pwrUpSlot), .resumeCfg(resumeCfg), .cfg_reg(cfg_reg),
        .activeSlot_reg(activeSlot_reg), .loadPulse_reg(loadPulse_reg),
        .txCarrierOn_reg(txCarrierOn_reg)
    );

    acr_demod_model #(.CFG_W(32)) u_demod (
        .clk(clk), .sys_rst(sys_rst), .cfg(cfg_reg), .goodCfg(goodCfg),
        .carrierLock(carrierLock)
    );

    // ----------------------------------------------------------------
    // Reporting
    // ----------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // A hang counts as a mismatch and ends in the normal report.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            n_errors++;
            stop_test();
        end
    end

    // ----------------------------------------------------------------
    // Bus tasks
    // ----------------------------------------------------------------
    // One-cycle write strobe; the gap edge keeps strobe drives apart.
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrStb <= 1'b1;
        @(posedge clk);
        wrStb <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe edge.
    task automatic rdw(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rdStb <= 1'b1;
        @(posedge clk);
        rdStb <= 1'b0;
        #1 d = rdData_reg;
    endtask : rdw

    // Count cycles until a load pulse, or stop at the limit.
    task automatic wait_load(input int lim, output int n);
        logic seen;
        seen = 1'b0;
        n = 0;
        while (!seen && n < lim) begin
            @(posedge clk);
            #1 n++;
            seen = (loadPulse_reg === 1'b1);
        end
    endtask : wait_load

    // One automatic step: slot, contents and dwell before entering it.
    task automatic step(input logic [3:0] s, input int t);
        wait_load(t * SEC + 12, cyc);
        chk("step slot", {28'h0, activeSlot_reg}, {28'h0, s});
        chk("step cfg", cfg_reg, 32'hC0DE_0000 + s);
        chk("step time", 32'(cyc >= t * SEC - 2 && cyc <= t * SEC + 10),
            1);
    endtask : step

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        #1 chk("resume cfg", cfg_reg, resumeCfg);
        for (int i = 8; i < 16; i++) begin
            rdw(4'(i), rd);
            chk("time reset", rd, 32'h0);
        end
        rdw(4'h1, rd);
        chk("stored mask", rd, 32'h0);
        rdw(4'h4, rd);
        chk("unmapped", rd, 32'h0);
        // An untouched slot recalls the factory set.
        wr(4'h1, 32'h0000_0025);
        wait_load(10, cyc);
        chk("blank slot", cfg_reg, FACT);
        for (int i = 0; i < 8; i++) begin
            wr(4'h2, 32'hC0DE_0000 + i);
            wr(4'h1, 32'h0000_0010 | i);
        end
        rdw(4'h1, rd);
        chk("stored mask", rd, 32'h0000_00FF);
        wr(4'h1, 32'h0000_0023);
        wait_load(10, cyc);
        chk("recall 3", cfg_reg, 32'hC0DE_0003);
        wr(4'h1, 32'h0000_0028);
        wait_load(10, cyc);
        chk("factory", cfg_reg, FACT);
        chk("factory id", {28'h0, activeSlot_reg}, 32'h8);
        // The time limit is inclusive; one above is refused.
        wr(4'h8, 32'd14400);
        wr(4'h8, 32'd14401);
        rdw(4'h8, rd);
        chk("time max", rd, 32'd14400);
        wr(4'h8, 32'h0);
        // Arm slots 1, 4 and 6; the others stay disabled.
        wr(4'h9, 32'd3);
        wr(4'hC, 32'd1);
        wr(4'hE, 32'd2);
        // Load the factory set so the first dwell starts from a load.
        wr(4'h1, 32'h0000_0028);
        wait_load(10, cyc);
        chk("rearm load", {28'h0, activeSlot_reg}, 32'h8);
        goodCfg <= NONE;
        step(4'h1, 3);
        step(4'h4, 1);
        step(4'h6, 2);
        step(4'h1, 3);
        goodCfg <= 32'hC0DE_0004;
        step(4'h4, 1);
        repeat (2 * SEC) @(posedge clk);
        rdw(4'h3, rd);
        chk("dwell on lock", {17'h0, rd[14:0]}, 32'h0);
        wait_load(6 * SEC, cyc);
        chk("stop on lock", 32'(cyc), 32'(6 * SEC));
        // A fresh loss starts over at the lowest armed slot, not slot 6.
        goodCfg <= NONE;
        step(4'h1, 3);
        @(posedge clk);
        redundMode <= 1'b1;
        repeat (2 * SEC + SEC / 2 - 3) @(posedge clk);
        rdw(4'h3, rd);
        chk("dwell secs", {17'h0, rd[14:0]}, 32'h2);
        chk("stat slot", {28'h0, rd[19:16]}, 32'h1);
        wait_load(5 * SEC, cyc);
        chk("redundant hold", 32'(cyc), 32'(5 * SEC));
        // Transmit enable alone, then mute while the carrier is absent.
        wr(4'h0, 32'h1);
        repeat (2) @(posedge clk);
        #1 chk("tx on", {31'h0, txCarrierOn_reg}, 32'h1);
        wr(4'h0, 32'h3);
        repeat (2) @(posedge clk);
        #1 chk("tx muted", {31'h0, txCarrierOn_reg}, 32'h0);
        goodCfg <= 32'hC0DE_0001;
        repeat (10) @(posedge clk);
        #1 chk("tx relock", {31'h0, txCarrierOn_reg}, 32'h1);
        @(posedge clk);
        redundMode <= 1'b0;
        // Second reset with a power-up recall of the third slot.
        pwrUpSlot <= 4'h3;
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        wait_load(10, cyc);
        chk("boot delay", 32'(cyc), 32'h3);
        chk("boot slot", {28'h0, activeSlot_reg}, 32'h2);
        chk("boot cfg", cfg_reg, FACT);
        stop_test();
    end
endmodule : tb
